// [rtl/lcdcr_regs.v]
// Panel driver control register bank on Avalon-MM
`timescale 1ns/1ps
`include "lcdcr_defs.vh"

// Summary of operation
// - Duty field: 10=1/16, 01=1/32, 00=1/8
// - Duty resets to 10, all else zero
// - Font bit: one=12x12, zero=16x16/5x8
// - Segment order bit reverses column-to-segment mapping
// - Area bit picks display memory area
// - Display state: lit, dark, normal, off
// - Reset and sleep force drive off
// - Four-bit contrast, sixteen levels, resets zero
// - Frame clock: oscillator or timer output
// - Booster enable bit, readable, resets off
// - Regulator source: boosted or main supply
// - Mode bit 7 heavy-load protection enable
// - Drive off grounds all bias outputs
module lcdcr_regs #(
	parameter SETTLE_CYCLES = `LCDCR_BOOST_SETTLE_CYC,
	parameter SEGS          = 96
) (
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_rst_n,
	// Avalon-MM slave
	input  wire [15:0] i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	// Processor events
	input  wire        i_sleep_instruction,
	// Clock sources for the frame signal
	input  wire        i_low_speed_osc_clock,
	input  wire        i_programmable_timer_out,
	// Column being scanned
	input  wire [6:0]  i_column,
	// Driver controls
	output reg  [1:0]  o_duty_sel,
	output reg  [5:0]  o_common_count,
	output reg         o_font_layout_sel,
	output reg         o_segment_order_reverse,
	output reg         o_display_area_sel,
	output reg  [1:0]  o_display_state,
	output reg         o_common_static,
	output reg         o_all_dots_lit,
	output reg         o_all_dots_dark,
	output reg  [3:0]  o_contrast,
	output reg         o_frame_clock_source,
	output reg         o_frame_clock,
	output reg         o_booster_enable,
	output reg         o_regulator_source_sel,
	output reg         o_heavy_load_mode,
	output reg         o_bias_power_on,
	output reg         o_booster_settled,
	output wire [6:0]  o_segment
);

	// ==========================================================
	// Register storage
	reg        booster_enable;
	reg        regulator_source_sel;
	reg  [7:0] mode_reg;
	reg  [7:0] state_reg;
	wire       settled;

	wire sel_pwr   = (i_avs_address == `LCDCR_OFS_POWER);
	wire sel_mode  = (i_avs_address == `LCDCR_OFS_MODE);
	wire sel_state = (i_avs_address == `LCDCR_OFS_STATE);
	wire wr        = i_avs_write & ~o_avs_waitrequest;
	wire rd        = i_avs_read & o_avs_waitrequest;

	// ==========================================================
	// Bus handshake: one wait cycle, answer on second edge
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
		end else if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b0;
		end else begin
			o_avs_waitrequest <= 1'b1;
		end
	end

	// ==========================================================
	// Register writes
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			booster_enable       <= 1'b0;
			regulator_source_sel <= 1'b0;
			mode_reg             <= `LCDCR_RST_MODE;
			state_reg            <= `LCDCR_RST_STATE;
		end else begin
			if (wr && sel_pwr) begin
				booster_enable       <= i_avs_writedata[`LCDCR_PWR_BOOST];
				regulator_source_sel <=
					i_avs_writedata[`LCDCR_PWR_REGSRC];
			end
			if (wr && sel_mode) begin
				mode_reg <= i_avs_writedata[7:0];
			end
			if (wr && sel_state) begin
				state_reg <= i_avs_writedata[7:0];
			end
			if (i_sleep_instruction) begin
				state_reg[`LCDCR_ST_DISP_HI:`LCDCR_ST_DISP_LO] <=
					`LCDCR_DISP_OFF;
			end
		end
	end

	// ==========================================================
	// Read path: loaded as the answer starts, so data stands
	// together with waitrequest low; unmapped addresses read zero
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_readdata <= 32'h00000000;
		end else if (rd) begin
			if (sel_pwr) begin
				o_avs_readdata <= {30'h00000000, regulator_source_sel,
					booster_enable};
			end else if (sel_mode) begin
				o_avs_readdata <= {24'h000000, mode_reg};
			end else if (sel_state) begin
				o_avs_readdata <= {24'h000000, state_reg};
			end else begin
				o_avs_readdata <= 32'h00000000;
			end
		end
	end

	// ==========================================================
	// Decoded driver controls
	wire [1:0] duty  = mode_reg[`LCDCR_MODE_DUTY_HI:`LCDCR_MODE_DUTY_LO];
	wire [1:0] disp  = state_reg[`LCDCR_ST_DISP_HI:`LCDCR_ST_DISP_LO];

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_duty_sel              <= `LCDCR_DUTY_16;
			o_common_count          <= 6'h10;
			o_font_layout_sel       <= 1'b0;
			o_segment_order_reverse <= 1'b0;
			o_display_area_sel      <= 1'b0;
			o_display_state         <= `LCDCR_DISP_OFF;
			o_common_static         <= 1'b0;
			o_all_dots_lit          <= 1'b0;
			o_all_dots_dark         <= 1'b0;
			o_contrast              <= 4'h0;
			o_frame_clock_source    <= 1'b0;
			o_frame_clock           <= 1'b0;
			o_booster_enable        <= 1'b0;
			o_regulator_source_sel  <= 1'b0;
			o_heavy_load_mode       <= 1'b0;
			o_bias_power_on         <= 1'b0;
			o_booster_settled       <= 1'b0;
		end else begin
			o_duty_sel <= duty;
			case (duty)
			`LCDCR_DUTY_16: o_common_count <= 6'h10;
			`LCDCR_DUTY_32: o_common_count <= 6'h20;
			`LCDCR_DUTY_8:  o_common_count <= 6'h08;
			default:        o_common_count <= 6'h10;
			endcase
			o_font_layout_sel       <= mode_reg[`LCDCR_MODE_FONT];
			o_segment_order_reverse <= mode_reg[`LCDCR_MODE_SEGMENT_ORDER_REVERSE];
			o_heavy_load_mode       <= mode_reg[`LCDCR_MODE_HEAVY];
			o_display_area_sel      <= state_reg[`LCDCR_ST_AREA];
			o_display_state         <= disp;
			o_all_dots_lit  <= (disp == `LCDCR_DISP_ALL_LIT);
			o_common_static <= (disp == `LCDCR_DISP_ALL_LIT);
			o_all_dots_dark <= (disp == `LCDCR_DISP_ALL_OUT);
			o_bias_power_on <= (disp != `LCDCR_DISP_OFF);
			o_contrast <=
				state_reg[`LCDCR_ST_CONTR_HI:`LCDCR_ST_CONTR_LO];
			o_frame_clock_source <= state_reg[`LCDCR_ST_FRMSRC];
			o_frame_clock <= state_reg[`LCDCR_ST_FRMSRC] ?
				i_programmable_timer_out : i_low_speed_osc_clock;
			o_booster_enable       <= booster_enable;
			o_regulator_source_sel <= regulator_source_sel;
			o_booster_settled      <= settled;
		end
	end

	// ==========================================================
	// Helpers
	lcdcr_settle #(
		.CYCLES (SETTLE_CYCLES),
		.CW     (24)
	) u_settle (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_enable  (booster_enable),
		.o_settled (settled)
	);

	lcdcr_seg_map #(
		.SEGS (SEGS)
	) u_seg_map (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_reverse (mode_reg[`LCDCR_MODE_SEGMENT_ORDER_REVERSE]),
		.i_column  (i_column),
		.o_segment (o_segment)
	);

endmodule

// [rtl/lcdcr_defs.vh]
// Offsets, field positions, reset values and timing for the panel control bank
`ifndef LCDCR_DEFS_VH
`define LCDCR_DEFS_VH

// Register offsets, as printed, used as word indexes
`define LCDCR_OFS_POWER      16'hff03
`define LCDCR_OFS_MODE       16'hff10
`define LCDCR_OFS_STATE      16'hff11

// Power control fields
`define LCDCR_PWR_BOOST      0
`define LCDCR_PWR_REGSRC     1

// Mode control fields
`define LCDCR_MODE_DUTY_LO   0
`define LCDCR_MODE_DUTY_HI   1
`define LCDCR_MODE_FONT      2
`define LCDCR_MODE_SEGMENT_ORDER_REVERSE    6
`define LCDCR_MODE_HEAVY     7

// State and contrast fields
`define LCDCR_ST_CONTR_LO    0
`define LCDCR_ST_CONTR_HI    3
`define LCDCR_ST_DISP_LO     4
`define LCDCR_ST_DISP_HI     5
`define LCDCR_ST_AREA        6
`define LCDCR_ST_FRMSRC      7

// Reset values
`define LCDCR_RST_POWER      8'h00
`define LCDCR_RST_MODE       8'h02
`define LCDCR_RST_STATE      8'h00

// Duty codes
`define LCDCR_DUTY_8         2'h0
`define LCDCR_DUTY_32        2'h1
`define LCDCR_DUTY_16        2'h2

// Display state codes
`define LCDCR_DISP_OFF       2'h0
`define LCDCR_DISP_NORMAL    2'h1
`define LCDCR_DISP_ALL_OUT   2'h2
`define LCDCR_DISP_ALL_LIT   2'h3

// Booster settling time, for the status flag
`define LCDCR_BOOST_SETTLE_US 1000
`define LCDCR_CLK_MHZ         100
`define LCDCR_BOOST_SETTLE_CYC \
	(`LCDCR_BOOST_SETTLE_US * `LCDCR_CLK_MHZ)

`endif

// [rtl/lcdcr_seg_map.v]
// Segment order mapper: column address to segment number
`timescale 1ns/1ps
module lcdcr_seg_map #(
	parameter SEGS = 96
) (
	// Clock and reset
	input  wire       i_mclk,
	input  wire       i_rst_n,
	// Control
	input  wire       i_reverse,
	input  wire [6:0] i_column,
	// Result
	output reg  [6:0] o_segment
);

	wire [31:0] last_full;
	wire [6:0]  last_seg;

	assign last_full = SEGS - 1;
	assign last_seg  = last_full[6:0];

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_segment <= 7'h00;
		end else if (i_reverse) begin
			o_segment <= last_seg - i_column;
		end else begin
			o_segment <= i_column;
		end
	end

endmodule

// [rtl/lcdcr_settle.v]
// Settle timer: counts a fixed time after its enable rises
`timescale 1ns/1ps
module lcdcr_settle #(
	parameter CYCLES = 100000,
	parameter CW     = 17
) (
	// Clock and reset
	input  wire i_mclk,
	input  wire i_rst_n,
	// Control
	input  wire i_enable,
	// Status
	output reg  o_settled
);

	reg [CW-1:0] count;

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count     <= {CW{1'b0}};
			o_settled <= 1'b0;
		end else if (!i_enable) begin
			count     <= {CW{1'b0}};
			o_settled <= 1'b0;
		end else if (count == CYCLES[CW-1:0] - 1'b1) begin
			o_settled <= 1'b1;
		end else begin
			count     <= count + 1'b1;
		end
	end

endmodule

// [test/lcdcr_asserts.sv]
// Concurrent checks on the panel control bank ports
`timescale 1ns/1ps
module lcdcr_asserts (
	// Clock, reset and bus
	input logic        i_mclk,
	input logic        i_rst_n,
	input logic        i_avs_read,
	input logic        i_avs_write,
	input logic [31:0] o_avs_readdata,
	input logic        o_avs_waitrequest,
	// Controls
	input logic        i_sleep_instruction,
	input logic [6:0]  i_column,
	input logic [6:0]  o_segment,
	input logic        o_segment_order_reverse,
	input logic [1:0]  o_duty_sel,
	input logic [5:0]  o_common_count,
	input logic [1:0]  o_display_state,
	input logic        o_bias_power_on,
	input logic        o_all_dots_lit,
	input logic        o_common_static,
	input logic        o_all_dots_dark,
	// Frame clock
	input logic        i_low_speed_osc_clock,
	input logic        i_programmable_timer_out,
	input logic        o_frame_clock_source,
	input logic        o_frame_clock
);
	// ====
	// Properties
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic [1:0] rev_h;
	always @(posedge i_mclk)
		rev_h <= {rev_h[0], o_segment_order_reverse};
	property p_answer;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_stand;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_stand: assert property (p_stand) else $error("long answer");
	property p_rdhi;
		!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
	endproperty
	a_rdhi: assert property (p_rdhi) else $error("high read bits");
	property p_sleep;
		i_sleep_instruction |-> ##2 o_display_state == 2'h0;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep kept drive");
	property p_bias;
		o_bias_power_on == (o_display_state != 2'h0);
	endproperty
	a_bias: assert property (p_bias) else $error("bias power wrong");
	property p_lit;
		$rose(o_display_state == 2'h3) |-> o_all_dots_lit && o_common_static;
	endproperty
	a_lit: assert property (p_lit) else $error("all lit wrong");
	property p_duty;
		o_common_count == (o_duty_sel == 2'h0 ? 6'h08 :
			o_duty_sel == 2'h1 ? 6'h20 : 6'h10);
	endproperty
	a_duty: assert property (p_duty) else $error("common count wrong");
	property p_seg;
		rev_h == {2{o_segment_order_reverse}} |-> o_segment ==
			(o_segment_order_reverse ? 7'h5f - $past(i_column) : $past(i_column));
	endproperty
	a_seg: assert property (p_seg) else $error("segment order wrong");
	property p_dark;
		o_all_dots_dark == (o_display_state == 2'h2);
	endproperty
	a_dark: assert property (p_dark) else $error("all dark wrong");
	property p_frame;
		o_frame_clock == (o_frame_clock_source ?
			$past(i_programmable_timer_out) : $past(i_low_speed_osc_clock));
	endproperty
	a_frame: assert property (p_frame) else $error("frame clock wrong");
	c_sleep: cover property (i_sleep_instruction);
	c_rev: cover property (o_segment_order_reverse);
	c_lit: cover property (o_all_dots_lit);
endmodule

// [test/lcdcr_panel.sv]
// Panel-side model: column scan and frame clock sources
`timescale 1ns/1ps
module lcdcr_panel (
	// Clock and reset
	input  logic       i_mclk,
	input  logic       i_rst_n,
	// Scan and clock sources
	output logic [6:0] o_column,
	output logic       o_osc,
	output logic       o_timer
);
	logic [3:0] div;
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_column <= 7'h00;
			div      <= 4'h0;
		end else begin
			o_column <= (o_column == 7'h5f) ? 7'h00 : o_column + 7'h01;
			div      <= div + 4'h1;
		end
	end
	assign o_osc   = div[3];
	assign o_timer = div[1];
endmodule

// [test/lcdcr_regs_test.sv]
// Self-checking bench for the panel control register bank
`timescale 1ns/1ps
module lcdcr_regs_test;
	logic        i_mclk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [31:0] wd = 32'h0;
	logic        rd = 1'b0, wr = 1'b0, sleep_instruction = 1'b0;
	logic [31:0] rdata;
	logic [6:0]  col;
	logic [5:0]  ncom;
	logic [3:0]  contr;
	logic [1:0]  duty, ds;
	logic [7:0]  q;
	logic        osc, tmr, wq, font, rev, area, lit, frm, boost, rsrc;
	logic        heavy, bias, stl;
	int          failures = 0;
	int          n_compared = 0;
	// ====
	// Design and partner
	lcdcr_regs #(.SETTLE_CYCLES(20)) uut (.i_mclk, .i_rst_n,
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
		.i_sleep_instruction(sleep_instruction), .i_low_speed_osc_clock(osc),
		.i_programmable_timer_out(tmr), .i_column(col), .o_duty_sel(duty),
		.o_common_count(ncom), .o_font_layout_sel(font),
		.o_segment_order_reverse(rev), .o_display_area_sel(area),
		.o_display_state(ds), .o_common_static(), .o_all_dots_lit(lit),
		.o_all_dots_dark(), .o_contrast(contr), .o_frame_clock_source(frm),
		.o_frame_clock(), .o_booster_enable(boost),
		.o_regulator_source_sel(rsrc), .o_heavy_load_mode(heavy),
		.o_bias_power_on(bias), .o_booster_settled(stl), .o_segment());
	lcdcr_panel u_panel (.i_mclk, .i_rst_n, .o_column(col), .o_osc(osc),
		.o_timer(tmr));
	always #5 i_mclk = ~i_mclk;
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge i_mclk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= {24'h0, d};
		for (n = 0; n < 40 && (n == 0 || wq !== 1'b0); n++)
			@(posedge i_mclk);
		if (n >= 40) begin
			failures++;
			$display("MISMATCH answer exp 0 got %b", wq);
		end
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task rchk(input string s, input logic [15:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(s, e, q);
	endtask
	task t_reset;
		rchk("power", 16'hff03, 8'h00);
		rchk("mode", 16'hff10, 8'h02);
		rchk("state", 16'hff11, 8'h00);
		chk("ncom", 8'h10, {2'h0, ncom});
		chk("duty", 8'h02, {6'h0, duty});
	endtask
	task t_power;
		bus(1'b1, 16'hff03, 8'h01);
		repeat (15) @(posedge i_mclk);
		chk("early", 8'h00, {7'h0, stl});
		repeat (10) @(posedge i_mclk);
		chk("settled", 8'h01, {7'h0, stl});
		bus(1'b1, 16'hff03, 8'hff);
		rchk("power", 16'hff03, 8'h03);
		chk("pwr", 8'h03, {6'h0, rsrc, boost});
		bus(1'b1, 16'hff03, 8'h00);
		rchk("power", 16'hff03, 8'h00);
		chk("pwr", 8'h00, {5'h0, stl, rsrc, boost});
	endtask
	task t_mode;
		logic [7:0] m, e;
		for (int i = 0; i < 3; i++) begin
			m = {6'h3f, 2'(i)};
			e = (i == 0) ? 8'h08 : (i == 1) ? 8'h20 : 8'h10;
			bus(1'b1, 16'hff10, m);
			rchk("mode", 16'hff10, m);
			chk("ncom", e, {2'h0, ncom});
			chk("ctl", m, {heavy, rev, 3'h7, font, duty});
		end
		bus(1'b1, 16'hff10, 8'h02);
		rchk("mode", 16'hff10, 8'h02);
		chk("ctl", 8'h02, {heavy, rev, 3'h0, font, duty});
	endtask
	task t_state;
		logic [7:0] v;
		for (int k = 0; k < 4; k++) begin
			v = {2'(k), 2'(k), 4'(k * 5)};
			bus(1'b1, 16'hff11, v);
			rchk("state", 16'hff11, v);
			chk("outs", v, {frm, area, ds, contr});
			chk("drive", {6'h0, k == 3, k != 0}, {6'h0, lit, bias});
		end
	endtask
	task t_sleep;
		bus(1'b1, 16'hff11, 8'hd5);
		@(posedge i_mclk);
		sleep_instruction <= 1'b1;
		@(posedge i_mclk);
		sleep_instruction <= 1'b0;
		rchk("sleep", 16'hff11, 8'hc5);
		chk("ds", 8'h00, {6'h0, ds});
		bus(1'b1, 16'h0000, 8'hff);
		rchk("unmapped", 16'h0000, 8'h00);
	endtask
	task end_sim;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset;
		t_power;
		t_mode;
		t_state;
		t_sleep;
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset;
		end_sim;
	end
endmodule
bind lcdcr_regs lcdcr_asserts u_chk (.i_mclk, .i_rst_n, .i_avs_read,
	.i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_sleep_instruction,
	.i_column, .o_segment, .o_segment_order_reverse, .o_duty_sel,
	.o_common_count, .o_display_state, .o_bias_power_on, .o_all_dots_lit,
	.o_common_static, .o_all_dots_dark, .i_low_speed_osc_clock,
	.i_programmable_timer_out, .o_frame_clock_source, .o_frame_clock);
